/* logic/card_cmd_pkg.sv */
// Package of offsets, fields, commands and timing for the card command interpreter.
package card_cmd_pkg;
  // ---------------------------------------------------------------
  // Register offsets (word index; byte address is four times it)
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_DATA      = 4'h0;
  localparam logic [3:0] IDX_FEATURE   = 4'h1;
  localparam logic [3:0] IDX_SEC_COUNT = 4'h2;
  localparam logic [3:0] IDX_SEC_NUM   = 4'h3;
  localparam logic [3:0] IDX_CYL_LOW   = 4'h4;
  localparam logic [3:0] IDX_CYL_HIGH  = 4'h5;
  localparam logic [3:0] IDX_DRV_HEAD  = 4'h6;
  localparam logic [3:0] IDX_COMMAND   = 4'h7;
  localparam logic [3:0] IDX_ID_WORD   = 4'h8;
  localparam logic [3:0] IDX_STATE     = 4'h9;
  localparam logic [3:0] IDX_CONFIG    = 4'ha;
  localparam logic [3:0] IDX_APD_TIMER = 4'hb;
  localparam logic [3:0] IDX_CHALLENGE = 4'hc;
  localparam logic [3:0] IDX_CHAL_HIGH = 4'hd;

  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_IDLE_A     = 8'h97;
  localparam logic [7:0] CMD_IDLE_B     = 8'he3;
  localparam logic [7:0] CMD_IDLE_IMM_A = 8'h95;
  localparam logic [7:0] CMD_IDLE_IMM_B = 8'he1;
  localparam logic [7:0] CMD_INIT_PARAM = 8'h91;
  localparam logic [7:0] CMD_KEY_MGMT   = 8'hb9;

  // ---------------------------------------------------------------
  // Identify word numbers and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] WORD_FEAT_SUP   = 8'h53;
  localparam logic [7:0] WORD_ERASE      = 8'h59;
  localparam logic [7:0] WORD_ERASE_ENH  = 8'h5a;
  localparam logic [7:0] WORD_APM        = 8'h5b;
  localparam logic [7:0] WORD_SEC_STAT   = 8'h80;
  localparam logic [7:0] WORD_POWER      = 8'ha0;
  localparam logic [7:0] WORD_KEY_SCHEME = 8'ha2;
  localparam int BIT_APM_SUP   = 3;
  localparam int BIT_SEC_LEVEL = 8;
  localparam int BIT_ENH_ERASE = 5;
  localparam int BIT_EXPIRE    = 4;
  localparam int BIT_FROZEN    = 3;
  localparam int BIT_LOCKED    = 2;
  localparam int BIT_SEC_EN    = 1;
  localparam int BIT_SEC_CAP   = 0;
  localparam int BIT_PWR_VALID = 15;
  localparam int BIT_PWR_RSV   = 14;
  localparam int BIT_NO_L1     = 13;
  localparam int BIT_L1_DIS    = 12;
  localparam int CURRENT_W     = 12;
  localparam logic [7:0] KM_FEATURE_LIMIT = 8'h80;
  localparam logic [15:0] FEAT_SUP_BASE   = 16'h4004;

  // ---------------------------------------------------------------
  // Status, timing and structure sizes
  // ---------------------------------------------------------------
  localparam int BIT_ST_BUSY  = 7;
  localparam int BIT_ST_DRQ   = 3;
  localparam int BIT_ST_ERR   = 0;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam int STRUCT_WORDS = 256;
  localparam int APD_UNIT_MS  = 5;
  localparam int CLOCK_MHZ    = 100;
  localparam int APD_UNIT_CYCLES = APD_UNIT_MS * 1000 * CLOCK_MHZ;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DATA_IN} cmd_state_t;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] sec_count;
    logic [7:0] sec_num;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] drv_head;
  } task_file_t;

  typedef struct packed {
    logic       busy;
    logic       drq;
    logic       err;
  } card_status_t;
endpackage

/* logic/card_cmd_top.sv */
// Command interpreter with identify tail words, idle and key management commands.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module card_cmd_top
  import card_cmd_pkg::*;
#(
  parameter logic [7:0]  ERASE_CODE     = 8'h00,
  parameter logic [7:0]  ERASE_ENH_CODE = 8'h00,
  parameter logic [11:0] MAX_CURRENT_MA = 12'h000,
  parameter int          APD_UNIT       = APD_UNIT_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [5:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic        hard_reset_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  output logic             intrq_out,
  output logic             idle_mode_out,
  output logic             power_down_out
);
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire        req      = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire [3:0]  idx      = wb_adr_in[5:2];
  wire        wr_lo    = req && wb_we_in && wb_sel_in[0];
  wire        wr_hi    = req && wb_we_in && wb_sel_in[1];
  wire        status_rd = req && !wb_we_in && idx == IDX_COMMAND;

  task_file_t   tf_q;
  card_status_t st_q;
  cmd_state_t   state_q;
  logic [7:0]   error_q;
  logic [7:0]   cmd_q;
  logic [7:0]   id_word_sel_q;
  logic [7:0]   apm_level_q;
  logic [15:0]  config_q;
  logic [7:0]   sectors_per_track_q;
  logic [3:0]   max_head_q;
  logic [7:0]   apd_count_q;
  logic         apd_en_q;
  logic [31:0]  apd_tick_q;
  logic [7:0]   apd_units_q;
  logic [7:0]   xfer_left_q;
  logic         expired_q;
  logic [38:0]  challenge_q;

  // Config fields: 0 capable, 1 enabled, 2 locked, 3 frozen, 4 maximum level,
  // 5 level one absent, 6 level one disabled, 7 scheme present, 8 mode one, 9 apm support.
  wire sec_cap  = config_q[0];
  wire sec_en   = config_q[1] && sec_cap;
  wire scheme   = config_q[7];
  wire pwr_mode1 = config_q[8];

  // ---------------------------------------------------------------
  // Identify tail words
  // ---------------------------------------------------------------
  logic [15:0] id_word;
  wire [15:0] sec_word = {7'h00, sec_en && config_q[4], 2'b00, sec_cap, expired_q,
                          config_q[3], config_q[2], sec_en, sec_cap};
  wire [15:0] pwr_word = {pwr_mode1, 1'b0, config_q[5], config_q[6], MAX_CURRENT_MA};
  always_comb begin
    unique case (id_word_sel_q)
      WORD_FEAT_SUP:   id_word = FEAT_SUP_BASE | (16'(config_q[9]) << BIT_APM_SUP);
      WORD_ERASE:      id_word = {8'h00, ERASE_CODE};
      WORD_ERASE_ENH:  id_word = {8'h00, ERASE_ENH_CODE};
      WORD_APM:        id_word = {8'h00, apm_level_q};
      WORD_SEC_STAT:   id_word = sec_word;
      WORD_POWER:      id_word = pwr_word;
      WORD_KEY_SCHEME: id_word = {15'h0000, scheme};
      default:         id_word = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire cmd_wr   = wr_lo && idx == IDX_COMMAND && !st_q.busy && state_q == ST_IDLE;
  wire [7:0] c  = wb_dat_in[7:0];
  wire is_idle  = c == CMD_IDLE_A || c == CMD_IDLE_B;
  wire is_imm   = c == CMD_IDLE_IMM_A || c == CMD_IDLE_IMM_B;
  wire is_init  = c == CMD_INIT_PARAM;
  wire is_km    = c == CMD_KEY_MGMT && tf_q.feature < KM_FEATURE_LIMIT;
  wire exec_done = state_q == ST_EXEC;
  wire data_rd  = req && !wb_we_in && idx == IDX_DATA && state_q == ST_DATA_IN;
  wire last_word = data_rd && xfer_left_q == 8'h01;
  // Unlock and erase-unit attempts would land here once the security engine decodes them.
  wire apd_wrap = apd_tick_q == 32'(APD_UNIT - 1);

  logic [31:0] rd_data;
  always_comb begin
    unique case (idx)
      IDX_DATA:      rd_data = {16'h0000, 16'(xfer_left_q) ^ {9'h000, challenge_q[6:0]}};
      IDX_FEATURE:   rd_data = {24'h0, error_q};
      IDX_SEC_COUNT: rd_data = {24'h0, tf_q.sec_count};
      IDX_SEC_NUM:   rd_data = {24'h0, tf_q.sec_num};
      IDX_CYL_LOW:   rd_data = {24'h0, tf_q.cyl_low};
      IDX_CYL_HIGH:  rd_data = {24'h0, tf_q.cyl_high};
      IDX_DRV_HEAD:  rd_data = {24'h0, tf_q.drv_head};
      IDX_COMMAND:   rd_data = {24'h0, st_q.busy, 3'b000, st_q.drq, 2'b00, st_q.err};
      IDX_ID_WORD:   rd_data = {16'h0000, id_word};
      IDX_STATE:     rd_data = {12'h000, max_head_q, sectors_per_track_q, apd_count_q};
      IDX_CONFIG:    rd_data = {8'h00, apm_level_q, config_q};
      IDX_APD_TIMER: rd_data = {23'h0, apd_en_q, apd_units_q};
      IDX_CHALLENGE: rd_data = challenge_q[31:0];
      IDX_CHAL_HIGH: rd_data = {25'h0, challenge_q[38:32]};
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus slave and task file
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      wb_dat_out <= req ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tf_q          <= '0;
      id_word_sel_q <= 8'h00;
      apm_level_q   <= 8'h00;
      config_q      <= 16'h0000;
    end else if (wr_lo && !st_q.busy) begin
      unique case (idx)
        IDX_FEATURE:   tf_q.feature   <= c;
        IDX_SEC_COUNT: tf_q.sec_count <= c;
        IDX_SEC_NUM:   tf_q.sec_num   <= c;
        IDX_CYL_LOW:   tf_q.cyl_low   <= c;
        IDX_CYL_HIGH:  tf_q.cyl_high  <= c;
        IDX_DRV_HEAD:  tf_q.drv_head  <= c;
        IDX_ID_WORD:   id_word_sel_q  <= c;
        IDX_CONFIG: begin
          config_q[7:0] <= c;
          if (wr_hi) config_q[15:8] <= wb_dat_in[15:8];
          if (wb_sel_in[2]) apm_level_q <= wb_dat_in[23:16];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command engine
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q     <= ST_IDLE;
      st_q        <= '0;
      error_q     <= 8'h00;
      cmd_q       <= 8'h00;
      intrq_out   <= 1'b0;
      idle_mode_out <= 1'b0;
      xfer_left_q <= 8'h00;
      challenge_q <= '0;
      sectors_per_track_q <= 8'h00;
      max_head_q  <= 4'h0;
      apd_count_q <= 8'h00;
      apd_en_q    <= 1'b0;
    end else begin
      if (status_rd) intrq_out <= 1'b0;
      unique case (state_q)
        ST_IDLE: if (cmd_wr) begin
          cmd_q    <= c;
          st_q     <= '{busy: 1'b1, drq: 1'b0, err: 1'b0};
          error_q  <= 8'h00;
          state_q  <= ST_EXEC;
        end
        ST_EXEC: begin
          st_q.busy <= 1'b0;
          intrq_out <= 1'b1;
          state_q   <= ST_IDLE;
          if (cmd_q == CMD_IDLE_A || cmd_q == CMD_IDLE_B) begin
            idle_mode_out <= 1'b1;
            apd_count_q <= tf_q.sec_count;
            apd_en_q    <= tf_q.sec_count != 8'h00;
          end else if (cmd_q == CMD_IDLE_IMM_A || cmd_q == CMD_IDLE_IMM_B) begin
            idle_mode_out <= 1'b1;
          end else if (cmd_q == CMD_INIT_PARAM) begin
            sectors_per_track_q <= tf_q.sec_count;
            max_head_q <= tf_q.drv_head[3:0];
          end else if (cmd_q == CMD_KEY_MGMT && tf_q.feature < KM_FEATURE_LIMIT && scheme) begin
            challenge_q <= {tf_q.feature[6:0], tf_q.sec_count, tf_q.sec_num, tf_q.cyl_low, tf_q.cyl_high};
            st_q.drq    <= 1'b1;
            xfer_left_q <= 8'(STRUCT_WORDS - 1) + 8'h01;
            state_q     <= ST_DATA_IN;
          end else begin
            st_q.err <= 1'b1;
            error_q  <= ERR_ABORT;
          end
        end
        ST_DATA_IN: if (data_rd) begin
          xfer_left_q <= xfer_left_q - 8'h01;
          if (last_word) begin
            st_q.drq <= 1'b0;
            state_q  <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Auto power down timer
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      apd_tick_q     <= 32'h0000_0000;
      apd_units_q    <= 8'h00;
      power_down_out <= 1'b0;
    end else if (st_q.busy || !apd_en_q) begin
      apd_tick_q     <= 32'h0000_0000;
      apd_units_q    <= 8'h00;
      power_down_out <= 1'b0;
    end else if (!power_down_out) begin
      apd_tick_q <= apd_wrap ? 32'h0000_0000 : apd_tick_q + 32'h0000_0001;
      if (apd_wrap) begin
        apd_units_q    <= apd_units_q + 8'h01;
        power_down_out <= apd_units_q + 8'h01 == apd_count_q;
      end
    end
  end

  // The expired flag survives every soft event; only power-on or hard reset clears it.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) expired_q <= 1'b0;
    else if (config_q[10]) expired_q <= 1'b1;
    else if (hard_reset_in) expired_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_cmd_taken; cmd_wr && (is_idle || is_imm || is_init); endsequence
  a_busy_then_irq: assert property (s_cmd_taken |=> st_q.busy ##1 (!st_q.busy && intrq_out))
    else $error("Non-data command did not complete in two cycles.");
  a_apd_zero_off: assert property (exec_done && (cmd_q == CMD_IDLE_A || cmd_q == CMD_IDLE_B) && tf_q.sec_count == 8'h00 |=> !apd_en_q)
    else $error("Zero idle count left auto power down on.");
  a_imm_keeps_timer: assert property (exec_done && (cmd_q == CMD_IDLE_IMM_A || cmd_q == CMD_IDLE_IMM_B) |=> $stable(apd_count_q) && $stable(apd_en_q))
    else $error("Idle immediate changed the timer.");
  a_geometry_load: assert property (exec_done && cmd_q == CMD_INIT_PARAM |=> sectors_per_track_q == $past(tf_q.sec_count))
    else $error("Sector count not loaded into geometry.");
  a_km_data_in: assert property (cmd_wr && is_km && scheme |=> ##1 st_q.drq && !st_q.err)
    else $error("Key structure read did not start data-in.");
  a_km_abort: assert property (cmd_wr && c == CMD_KEY_MGMT && !scheme |=> ##1 st_q.err)
    else $error("Key read without scheme was not aborted.");
  a_pwr_reserved: assert property (id_word_sel_q == WORD_POWER |-> !id_word[BIT_PWR_RSV])
    else $error("Reserved power bit set.");
  a_expire_sticky: assert property (expired_q && !hard_reset_in |=> expired_q)
    else $error("Expired flag cleared without hard reset.");
  a_sec_level: assert property (id_word_sel_q == WORD_SEC_STAT && !sec_en |-> !id_word[BIT_SEC_LEVEL])
    else $error("Maximum level shown with security disabled.");
endmodule
`default_nettype wire

/* tb/wb_host_model.sv */
// Host controller model that runs classic Wishbone single cycles.
`timescale 1ns/1ns
`default_nettype none
module wb_host_model (
  input  wire logic        clock_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] dat_in,
  output logic             cyc_out,
  output logic             stb_out,
  output logic             we_out,
  output logic [5:0]       adr_out,
  output logic [3:0]       sel_out,
  output logic [31:0]      dat_out
);
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out  = 1'b0;
    adr_out = 6'h00;
    sel_out = 4'h0;
    dat_out = 32'h0;
  end
  // The request is held until ack is sampled or 64 cycles pass; released lines show inverted values so stale data never looks valid.
  task automatic cycle(input logic we, input logic [5:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = 32'h0;
    @(posedge clock_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out  <= we;
    adr_out <= adr;
    sel_out <= 4'hf;
    dat_out <= wd;
    for (int i = 0; i < 64 && !ok; i++) begin
      @(posedge clock_in);
      if (ack_in === 1'b1) begin
        ok = 1'b1;
        rd = dat_in;
      end
    end
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out  <= ~we;
    adr_out <= ~adr;
    sel_out <= 4'h0;
    dat_out <= ~wd;
  endtask
endmodule
`default_nettype wire

/* tb/card_cmd_top_tb.sv */
// Self-checking bench for the card command interpreter.
`timescale 1ns/1ns
`default_nettype none
module card_cmd_top_tb;
  import card_cmd_pkg::*;
  localparam logic [7:0]  ERASE_T = 8'hff;
  localparam logic [7:0]  ERASE_E = 8'h7f;
  localparam logic [11:0] CURR_MA = 12'h1f4;
  localparam int          UNIT    = 4;
  logic        clock_in      = 1'b0;
  logic        rst_n_in      = 1'b0;
  logic        hard_reset_in = 1'b0;
  logic        cyc, stb, we, ack, intrq, idle_mode, power_down;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          n_errors  = 0;
  int          cmp_count = 0;
  always #5 clock_in = ~clock_in;
  wb_host_model wb_host_model_inst (.clock_in(clock_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc),
    .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));
  card_cmd_top #(.ERASE_CODE(ERASE_T), .ERASE_ENH_CODE(ERASE_E), .MAX_CURRENT_MA(CURR_MA), .APD_UNIT(UNIT))
  card_cmd_top_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .hard_reset_in(hard_reset_in),
    .wb_dat_out(rdat), .wb_ack_out(ack), .intrq_out(intrq), .idle_mode_out(idle_mode),
    .power_down_out(power_down));
  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic hang(input string msg);
    n_errors++;
    $display("unexpected at %0t: %s never answered", $time, msg);
    print_verdict();
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        ok;
    wb_host_model_inst.cycle(1'b1, {idx, 2'b00}, d, r, ok);
    if (!ok) hang("bus write");
  endtask
  task automatic rd(input logic [3:0] idx, output logic [31:0] d);
    logic ok;
    wb_host_model_inst.cycle(1'b0, {idx, 2'b00}, 32'h0, d, ok);
    if (!ok) hang("bus read");
  endtask
  task automatic wait_intrq();
    for (int i = 0; i < 50 && intrq !== 1'b1; i++) @(posedge clock_in);
    if (intrq !== 1'b1) hang("interrupt");
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic ident_words(input logic [15:0] cfg, input logic [7:0] apm);
    logic [7:0]  w[7];
    logic [15:0] e[7];
    logic [31:0] r;
    w = '{WORD_FEAT_SUP, WORD_ERASE, WORD_ERASE_ENH, WORD_APM, WORD_SEC_STAT, WORD_POWER, WORD_KEY_SCHEME};
    e = '{FEAT_SUP_BASE | {12'h0, cfg[9], 3'h0}, {8'h0, ERASE_T}, {8'h0, ERASE_E}, {8'h0, apm},
          {7'h0, cfg[0] & cfg[1] & cfg[4], 2'h0, cfg[0], cfg[10], cfg[3:2], cfg[1] & cfg[0], cfg[0]},
          {cfg[8], 1'b0, cfg[5], cfg[6], CURR_MA}, {15'h0, cfg[7]}};
    // The expiry event must be settled before the hard reset, since a standing event wins over the clear.
    wr(IDX_CONFIG, {8'h0, apm, cfg});
    @(posedge clock_in);
    hard_reset_in <= 1'b1;
    @(posedge clock_in);
    hard_reset_in <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wr(IDX_ID_WORD, {24'h0, w[i]});
      rd(IDX_ID_WORD, r);
      check({16'h0, r[15:0]}, {16'h0, e[i]}, "identify word");
    end
  endtask
  task automatic idle_cmds();
    logic [7:0]  code[4];
    logic [7:0]  cnt[4];
    logic [31:0] apd[4];
    logic [31:0] r;
    logic        en;
    code = '{CMD_IDLE_A, CMD_IDLE_IMM_A, CMD_IDLE_IMM_B, CMD_IDLE_B};
    cnt  = '{8'h03, 8'h00, 8'h00, 8'h00};
    apd  = '{32'h103, 32'h103, 32'h103, 32'h000};
    for (int i = 0; i < 4; i++) begin
      wr(IDX_SEC_COUNT, {24'h0, cnt[i]});
      wr(IDX_COMMAND, {24'h0, code[i]});
      wait_intrq();
      check({31'h0, idle_mode}, 32'h1, "idle mode");
      rd(IDX_COMMAND, r);
      check({31'h0, r[BIT_ST_BUSY]}, 32'h0, "busy after idle");
      rd(IDX_APD_TIMER, r);
      en = r[8];
      rd(IDX_STATE, r);
      check({23'h0, en, r[7:0]}, apd[i], "auto power down setting");
      @(posedge clock_in);
      #1;
      check({31'h0, intrq}, 32'h0, "interrupt cleared by status read");
      if (i == 0) begin
        for (int k = 0; k < 40 && power_down !== 1'b1; k++) @(posedge clock_in);
        check({31'h0, power_down}, 32'h1, "auto power down reached");
      end
    end
  endtask
  task automatic geometry();
    logic [31:0] r;
    wr(IDX_FEATURE, 32'hff);
    wr(IDX_SEC_NUM, 32'h11);
    wr(IDX_CYL_LOW, 32'h22);
    wr(IDX_CYL_HIGH, 32'h33);
    wr(IDX_SEC_COUNT, 32'h3f);
    wr(IDX_DRV_HEAD, 32'ha5);
    wr(IDX_COMMAND, {24'h0, CMD_INIT_PARAM});
    wait_intrq();
    rd(IDX_COMMAND, r);
    check({31'h0, r[BIT_ST_ERR]}, 32'h0, "geometry status");
    rd(IDX_STATE, r);
    check({20'h0, r[19:8]}, 32'h53f, "heads and sectors");
  endtask
  task automatic key_read();
    logic [31:0] r;
    r = 32'h0;
    wr(IDX_CONFIG, 32'h0080);
    wr(IDX_FEATURE, 32'h7f);
    wr(IDX_SEC_COUNT, 32'h87);
    wr(IDX_SEC_NUM, 32'h65);
    wr(IDX_CYL_LOW, 32'h43);
    wr(IDX_CYL_HIGH, 32'h21);
    wr(IDX_COMMAND, {24'h0, CMD_KEY_MGMT});
    for (int i = 0; i < 20 && r[BIT_ST_DRQ] !== 1'b1; i++) rd(IDX_COMMAND, r);
    check({31'h0, r[BIT_ST_DRQ]}, 32'h1, "structure ready");
    for (int i = 0; i < STRUCT_WORDS - 1; i++) rd(IDX_DATA, r);
    rd(IDX_COMMAND, r);
    check({31'h0, r[BIT_ST_DRQ]}, 32'h1, "last word pending");
    rd(IDX_DATA, r);
    rd(IDX_COMMAND, r);
    check({31'h0, r[BIT_ST_DRQ]}, 32'h0, "structure done");
    rd(IDX_CHALLENGE, r);
    check(r, 32'h87654321, "challenge low");
    rd(IDX_CHAL_HIGH, r);
    check({25'h0, r[6:0]}, 32'h7f, "challenge high");
    wr(IDX_CONFIG, 32'h0);
    wr(IDX_COMMAND, {24'h0, CMD_KEY_MGMT});
    r = 32'h80;
    for (int i = 0; i < 20 && r[BIT_ST_BUSY] !== 1'b0; i++) rd(IDX_COMMAND, r);
    check({31'h0, r[BIT_ST_ERR]}, 32'h1, "abort without scheme");
    rd(IDX_FEATURE, r);
    check(r, {24'h0, ERR_ABORT}, "abort code");
  endtask
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    ident_words(16'h07ff, 8'h80);
    ident_words(16'h0155, 8'h01);
    idle_cmds();
    geometry();
    key_read();
    rd(4'hf, r);
    check(r, 32'h0, "unmapped read");
    print_verdict();
  end
endmodule
`default_nettype wire
